// *** rtl/pwm_unit_params.svh ***
// Functional notes
// - period comes only from pclk via prescaler
// - reset sets pins input, registers to defaults
// - two-bit prescale field selects timer ratio
// - timer counts only while run bit set
// - unimplemented control bits read zero
// - period end clears timer, sets pin unless duty zero, latches duty
// - pin low when time base equals duty
// - duty writable anytime, takes effect next period
// - sleep freezes timer and pin level
`ifndef PWM_UNIT_PARAMS_SVH
`define PWM_UNIT_PARAMS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_UNIT1_CTRL   12'h000
`define OFS_UNIT2_CTRL   12'h004
`define OFS_DUTY1_UPPER  12'h008
`define OFS_DUTY2_UPPER  12'h00C
`define OFS_DUTY1_SHADOW 12'h010
`define OFS_DUTY2_SHADOW 12'h014
`define OFS_PERIOD_LIMIT 12'h018
`define OFS_TIMER_CTRL   12'h01C
`define OFS_TIMER_COUNT  12'h020
`define OFS_ALT_PIN_SEL  12'h024
`define OFS_PIN_DIR      12'h028
`define OFS_IRQ_STATUS   12'h02C
`define OFS_IRQ_MASK     12'h030
`define OFS_SLEEP_CTRL   12'h034
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define MODE_PWM_HI      2'h3
`define RUN_BIT          2
`define PRESC_LO         0
`define POST_LO          3
`define RST_PERIOD_LIMIT 8'hFF
`define RST_ZERO8        8'h00
`define RST_PIN_DIR      3'h7
`define CTRL_MASK        8'h3F
`define TCTRL_MASK       8'h7F
`endif

// *** rtl/pwm_unit_pkg.sv ***
package pwm_unit_pkg;
    // one duty channel state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] upper;
        logic [7:0] shadow;
        logic [1:0] low_latch;
        logic       pin;
    } chan_t;
    // common timer state
    typedef struct packed {
        logic [7:0] count;
        logic [3:0] presc;
        logic [3:0] post;
        logic       match_tick;
    } timer_t;
    // apb read answer
    typedef struct packed {
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_t;
endpackage

// *** rtl/pwm_channel.sv ***
`timescale 1ns/10ps
`include "pwm_unit_params.svh"
// one pulse channel: shadow duty latch and pin level
module pwm_channel
    import pwm_unit_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       period_end,
    input  wire logic       advance,
    input  wire logic [9:0] time_base,
    input  wire logic [7:0] ctrl,
    input  wire logic [7:0] upper,
    output logic      [7:0] shadow,
    output logic            pin
);
    chan_t st;       // registered state
    chan_t next_st;  // next state
    logic  pwm_mode; // unit in pulse mode

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ctrl = ctrl;
        next_st.upper = upper;
        pwm_mode = (ctrl[3:2] == `MODE_PWM_HI);
        if (!pwm_mode) begin
            // leaving pulse mode drops the pin
            next_st.pin = 1'b0;
        end else if (advance && period_end) begin
            // new period: latch duty, raise pin unless zero
            next_st.shadow = upper;
            next_st.low_latch = ctrl[5:4];
            next_st.pin = ({upper, ctrl[5:4]} != 10'h000);
        end else if (advance && time_base == {st.shadow, st.low_latch}) begin
            next_st.pin = 1'b0;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign shadow = st.shadow;
    assign pin = st.pin;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    latch_at_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (advance && period_end && ctrl[3:2] == `MODE_PWM_HI) |=> shadow == $past(upper))
        else $error("shadow not latched at period end");
    zero_duty_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (advance && period_end && {upper, ctrl[5:4]} == 10'h000) |=> !pin)
        else $error("pin raised with zero duty");
endmodule

// *** rtl/pwm_unit.sv ***
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "pwm_unit_params.svh"
// two pulse units sharing one period timer, apb slave
module pwm_unit
    import pwm_unit_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             pulse1_out_pin,
    output logic             pulse1_oe,
    output logic             pulse2_out_pin,
    output logic             pulse2_oe,
    output logic             pulse2_alt_pin,
    output logic             pulse2_alt_oe
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] unit1_ctrl;
        logic [7:0] unit2_ctrl;
        logic [7:0] duty1_upper;
        logic [7:0] duty2_upper;
        logic [7:0] period_limit;
        logic [7:0] timer_ctrl;
        logic [7:0] alt_sel;
        logic [2:0] pin_dir;     // 1 = input, driver off
        logic [1:0] irq_status;  // bit0 timer match, bit1 period end
        logic [1:0] irq_mask;
        logic       sleep;
        timer_t     tmr;
        apb_rsp_t   rsp;
    } regs_t;

    regs_t       r;              // registered state
    regs_t       next_r;         // next state
    logic        wr_en;          // write accepted this cycle
    logic        rd_en;          // read accepted this cycle
    logic        advance;        // one pclk/4 tick
    logic        timer_step;     // timer increment this tick
    logic        period_end;     // increment after count equals limit
    logic [1:0]  base_lo;        // low two bits of time base
    logic [9:0]  time_base;      // 10-bit time base
    logic [1:0]  next_lo;        // low time-base bits one pclk ahead
    logic [9:0]  next_base;      // time base one pclk ahead, for the channels
    logic [3:0]  presc_max;      // prescaler terminal value
    logic [7:0]  shadow1;        // unit 1 shadow duty
    logic [7:0]  shadow2;        // unit 2 shadow duty
    logic        pin1;           // unit 1 pin level
    logic        pin2;           // unit 2 pin level
    logic [1:0]  phase;          // clock phase for divide-by-one
    logic [1:0]  next_phase;     // next clock phase
    logic [1:0]  ev;             // this cycle's events
    logic        unmapped;       // address hits no register

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // ---------------------------------------------------------------
    // time base
    // ---------------------------------------------------------------
    // instruction-cycle phase: four pclk per timer input tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end

    // phase frozen in sleep
    always_comb begin
        next_phase = r.sleep ? phase : phase + 2'h1;
    end

    assign advance = (phase == 2'h3) && !r.sleep;

    // prescaler ratio decode
    always_comb begin
        if (r.timer_ctrl[`PRESC_LO+1]) begin
            presc_max = 4'hF;
        end else if (r.timer_ctrl[`PRESC_LO]) begin
            presc_max = 4'h3;
        end else begin
            presc_max = 4'h0;
        end
    end

    assign timer_step = advance && r.timer_ctrl[`RUN_BIT] && (r.tmr.presc[3:0] >= presc_max);
    assign period_end = timer_step && (r.tmr.count == r.period_limit);
    // low bits: clock phase at 1:1, prescaler bits otherwise
    always_comb begin
        if (presc_max == 4'h0) begin
            base_lo = phase;
        end else if (presc_max == 4'h3) begin
            base_lo = r.tmr.presc[1:0];
        end else begin
            base_lo = r.tmr.presc[3:2];
        end
    end
    assign time_base = {r.tmr.count, base_lo};
    // channels compare the coming time base, so the pin register
    // drops on the first cycle of the match and width is exact
    always_comb begin
        if (presc_max == 4'h0) begin
            next_lo = next_phase;
        end else if (presc_max == 4'h3) begin
            next_lo = next_r.tmr.presc[1:0];
        end else begin
            next_lo = next_r.tmr.presc[3:2];
        end
    end
    assign next_base = {next_r.tmr.count, next_lo};

    // ---------------------------------------------------------------
    // channels
    // ---------------------------------------------------------------
    pwm_channel u_chan1 (
        .pclk       (pclk),
        .presetn    (presetn),
        .period_end (period_end),
        .advance    (!r.sleep),
        .time_base  (next_base),
        .ctrl       (r.unit1_ctrl),
        .upper      (r.duty1_upper),
        .shadow     (shadow1),
        .pin        (pin1)
    );

    pwm_channel u_chan2 (
        .pclk       (pclk),
        .presetn    (presetn),
        .period_end (period_end),
        .advance    (!r.sleep),
        .time_base  (next_base),
        .ctrl       (r.unit2_ctrl),
        .upper      (r.duty2_upper),
        .shadow     (shadow2),
        .pin        (pin2)
    );

    // ---------------------------------------------------------------
    // register file and timer
    // ---------------------------------------------------------------
    always_comb begin
        next_r = r;
        ev = 2'h0;
        unmapped = 1'b0;
        next_r.rsp = '0;
        next_r.tmr.match_tick = 1'b0;
        // prescaler and timer
        if (advance && r.timer_ctrl[`RUN_BIT]) begin
            if (r.tmr.presc >= presc_max) begin
                next_r.tmr.presc = 4'h0;
            end else begin
                next_r.tmr.presc = r.tmr.presc + 4'h1;
            end
        end
        if (period_end) begin
            next_r.tmr.count = 8'h00;
            ev[1] = 1'b1;
            // postscaler divides only the flag rate
            if (r.tmr.post == r.timer_ctrl[`POST_LO+3:`POST_LO]) begin
                next_r.tmr.post = 4'h0;
                next_r.tmr.match_tick = 1'b1;
                ev[0] = 1'b1;
            end else begin
                next_r.tmr.post = r.tmr.post + 4'h1;
            end
        end else if (timer_step) begin
            next_r.tmr.count = r.tmr.count + 8'h01;
        end
        // address decode
        if (paddr == `OFS_UNIT1_CTRL) begin
            next_r.rsp.prdata = {24'h0, r.unit1_ctrl & `CTRL_MASK};
            if (wr_en && pstrb[0]) next_r.unit1_ctrl = pwdata[7:0] & `CTRL_MASK;
        end else if (paddr == `OFS_UNIT2_CTRL) begin
            next_r.rsp.prdata = {24'h0, r.unit2_ctrl & `CTRL_MASK};
            if (wr_en && pstrb[0]) next_r.unit2_ctrl = pwdata[7:0] & `CTRL_MASK;
        end else if (paddr == `OFS_DUTY1_UPPER) begin
            next_r.rsp.prdata = {24'h0, r.duty1_upper};
            if (wr_en && pstrb[0]) next_r.duty1_upper = pwdata[7:0];
        end else if (paddr == `OFS_DUTY2_UPPER) begin
            next_r.rsp.prdata = {24'h0, r.duty2_upper};
            if (wr_en && pstrb[0]) next_r.duty2_upper = pwdata[7:0];
        end else if (paddr == `OFS_DUTY1_SHADOW) begin
            next_r.rsp.prdata = {24'h0, shadow1};
        end else if (paddr == `OFS_DUTY2_SHADOW) begin
            next_r.rsp.prdata = {24'h0, shadow2};
        end else if (paddr == `OFS_PERIOD_LIMIT) begin
            next_r.rsp.prdata = {24'h0, r.period_limit};
            if (wr_en && pstrb[0]) next_r.period_limit = pwdata[7:0];
        end else if (paddr == `OFS_TIMER_CTRL) begin
            next_r.rsp.prdata = {24'h0, r.timer_ctrl & `TCTRL_MASK};
            if (wr_en && pstrb[0]) next_r.timer_ctrl = pwdata[7:0] & `TCTRL_MASK;
        end else if (paddr == `OFS_TIMER_COUNT) begin
            next_r.rsp.prdata = {24'h0, r.tmr.count};
            if (wr_en && pstrb[0]) next_r.tmr.count = pwdata[7:0];
        end else if (paddr == `OFS_ALT_PIN_SEL) begin
            next_r.rsp.prdata = {24'h0, r.alt_sel & 8'h03};
            if (wr_en && pstrb[0]) next_r.alt_sel = pwdata[7:0] & 8'h03;
        end else if (paddr == `OFS_PIN_DIR) begin
            next_r.rsp.prdata = {29'h0, r.pin_dir};
            if (wr_en && pstrb[0]) next_r.pin_dir = pwdata[2:0];
        end else if (paddr == `OFS_IRQ_STATUS) begin
            next_r.rsp.prdata = {30'h0, r.irq_status};
            if (wr_en && pstrb[0]) next_r.irq_status = r.irq_status & ~pwdata[1:0];
        end else if (paddr == `OFS_IRQ_MASK) begin
            next_r.rsp.prdata = {30'h0, r.irq_mask};
            if (wr_en && pstrb[0]) next_r.irq_mask = pwdata[1:0];
        end else if (paddr == `OFS_SLEEP_CTRL) begin
            next_r.rsp.prdata = {31'h0, r.sleep};
            if (wr_en && pstrb[0]) next_r.sleep = pwdata[0];
        end else begin
            unmapped = 1'b1;
            next_r.rsp.pslverr = psel && penable;
        end
        if (!rd_en) begin
            next_r.rsp.prdata = 32'h0;
        end
        // events set after clear: set wins
        next_r.irq_status = next_r.irq_status | ev;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.period_limit <= `RST_PERIOD_LIMIT;
            r.pin_dir <= `RST_PIN_DIR;
        end else begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign pready = 1'b1;
    // answer is presented combinationally from registered data
    assign prdata = rd_en ? next_r.rsp.prdata : 32'h0;
    assign pslverr = psel && penable && unmapped;
    assign irq = |(r.irq_status & r.irq_mask);
    assign pulse1_out_pin = pin1;
    assign pulse1_oe = !r.pin_dir[0];
    assign pulse2_out_pin = pin2;
    assign pulse2_oe = !r.pin_dir[1] && !r.alt_sel[0];
    assign pulse2_alt_pin = pin2;
    assign pulse2_alt_oe = !r.pin_dir[2] && r.alt_sel[0];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    timer_stops_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!r.timer_ctrl[`RUN_BIT] && !(wr_en && paddr == `OFS_TIMER_COUNT)) |=> $stable(r.tmr.count))
        else $error("timer moved while stopped");
    sleep_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.sleep && $past(r.sleep)) |-> $stable(pin1) && $stable(pin2))
        else $error("pin changed in sleep");
    wrap_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_end |=> r.tmr.count == 8'h00)
        else $error("timer not cleared at period end");
    ctrl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.unit1_ctrl[7:6] == 2'h0 && r.unit2_ctrl[7:6] == 2'h0 && !r.timer_ctrl[7])
        else $error("unimplemented bits set");
    div1_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_step && r.timer_ctrl[1:0] == 2'h0) |-> ##4 (timer_step || !r.timer_ctrl[`RUN_BIT] || r.sleep))
        else $error("divide-by-one step spacing wrong");
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.tmr.match_tick |-> r.irq_status[0])
        else $error("match flag not set");
    pin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.unit1_ctrl[3:2] == 2'h3 && !r.sleep && r.timer_ctrl[`RUN_BIT] && !period_end
         && time_base == {shadow1, u_chan1.st.low_latch}) |=> !pin1)
        else $error("pin not dropped at duty match");
    reset_dir_a: assert property (@(posedge pclk) $rose(presetn) |-> !pulse1_oe && !pulse2_oe)
        else $error("driver enabled out of reset");
    period_c: cover property (@(posedge pclk) disable iff (!presetn) period_end);
    irq_c:    cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    pin_c:    cover property (@(posedge pclk) disable iff (!presetn) $fell(pin1));
endmodule

// *** verif/pulse_load_model.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// external load on one pulse pin
// ---------------------------------------------------------------
// pulled low while the pin driver is off, measures pulse shape
module pulse_load_model (
    input  wire logic        pclk,
    input  wire logic        pin,
    input  wire logic        oe,
    output logic      [15:0] high_len,
    output logic      [15:0] period_len,
    output logic      [15:0] rises
);
    logic        pad;                  // wire level at the load
    logic        pad_q   = 1'b0;       // wire level one cycle back
    logic [15:0] run_cnt = 16'h0000;   // cycles since last rise
    initial high_len   = 16'h0000;
    initial period_len = 16'h0000;
    initial rises      = 16'h0000;
    // undriven line falls to the pull-down, never keeps a stale level
    assign pad = oe ? pin : 1'b0;
    // edge timing: rise to rise is the period, rise to fall the width
    always @(posedge pclk) begin
        pad_q   <= pad;
        run_cnt <= run_cnt + 16'h0001;
        if (pad && !pad_q) begin
            period_len <= run_cnt;
            run_cnt    <= 16'h0001;
            rises      <= rises + 16'h0001;
        end
        if (!pad && pad_q) begin
            high_len <= run_cnt;
        end
    end
endmodule

// *** verif/test_pwm_unit.sv ***
`timescale 1ns/10ps
`include "pwm_unit_params.svh"
// ---------------------------------------------------------------
// self-checking bench for the pulse unit
// ---------------------------------------------------------------
module test_pwm_unit
    import pwm_unit_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr  = 12'h000;     // apb address
    logic [31:0] pwdata = 32'h0;       // apb write data
    logic [31:0] prdata;               // apb read data
    logic pready, pslverr, irq, p1, p1_oe, p2, p2_oe, p2a, p2a_oe;
    logic [15:0] high_len, period_len, rises; // load measurements
    int miscompares = 0, check_count = 0, seed = 32'h1c25;
    logic [31:0] rd, rd2;              // read scratch
    logic [7:0]  lim;                  // period limit under test
    logic [9:0]  duty;                 // duty under test
    logic [15:0] r0;                   // edge count snapshot
    logic [11:0] rst_addr [9] = '{12'h000, 12'h004, 12'h018, 12'h01C, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h030};
    logic [31:0] rst_val  [9] = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0, 32'h0};

    pwm_unit pwm_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .pulse1_out_pin(p1), .pulse1_oe(p1_oe), .pulse2_out_pin(p2), .pulse2_oe(p2_oe),
        .pulse2_alt_pin(p2a), .pulse2_alt_oe(p2a_oe));
    pulse_load_model pulse_load_model_i (.pclk(pclk), .pin(p1), .oe(p1_oe), .high_len(high_len),
        .period_len(period_len), .rises(rises));

    // 50 MHz clock
    initial begin
        forever #10 pclk = ~pclk;
    end

    // ---------------------------------------------------------------
    // bench helpers
    // ---------------------------------------------------------------
    // prescaler ratio (timer input ticks, four pclk each, per timer step) for each prescale code
    function automatic int div_of(input int code);
        return (code == 0) ? 1 : (code == 1) ? 4 : 16;
    endfunction

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one compare, reported at once
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bounded wait ran out
    task automatic hang(input string name);
        miscompares++;
        $display("MISMATCH %s expected done seen timeout", name);
        summarize();
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) hang("pready");
        d   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, wd, d, e);
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask

    // clear the period-end flag and wait for it again
    task automatic wait_period();
        logic [31:0] s;
        int          n;
        wr(`OFS_IRQ_STATUS, 32'h2);
        n = 0;
        do begin
            rd_reg(`OFS_IRQ_STATUS, s);
            n++;
        end while (s[1] !== 1'b1 && n < 2000);
        if (n >= 2000) hang("period end");
    endtask

    // three rising edges at the load, so the last period and pulse are whole
    // even when the driver was switched on in the middle of a pulse
    task automatic measure();
        int n;
        r0 = rises;
        n  = 0;
        while (rises !== r0 + 16'h0003 && n < 8000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 8000) hang("pulse edges");
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic e;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, pins released
        chk("oe after reset", 32'h0, {29'h0, p1_oe, p2_oe, p2a_oe});
        for (int i = 0; i < 9; i++) begin
            rd_reg(rst_addr[i], rd);
            chk("reset value", rst_val[i], rd);
        end
        apb(1'b0, 12'h100, 32'h0, rd, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, rd);
        wr(`OFS_UNIT1_CTRL, 32'hFF);
        rd_reg(`OFS_UNIT1_CTRL, rd);
        chk("ctrl unused bits", 32'h3F, rd);
        wr(`OFS_TIMER_CTRL, 32'hFB);
        rd_reg(`OFS_TIMER_CTRL, rd);
        chk("timer ctrl unused bit", 32'h7B, rd);
        wr(`OFS_TIMER_CTRL, 32'h0);
        wr(`OFS_ALT_PIN_SEL, 32'h1);
        wr(`OFS_PIN_DIR, 32'h3);
        @(posedge pclk);
        chk("alt pin drive", 32'h1, {29'h0, p1_oe, p2_oe, p2a_oe});
        $display("test registers done");
        // setup sequence, one pass per prescale code
        for (int k = 0; k < 4; k++) begin
            lim  = 8'($unsigned($random(seed)) % 12 + 2);
            duty = 10'($unsigned($random(seed)) % (4 * (lim + 1) - 1) + 1);
            wr(`OFS_PIN_DIR, 32'h7);
            wr(`OFS_TIMER_CTRL, 32'h0);
            wr(`OFS_TIMER_COUNT, 32'h0);
            wr(`OFS_PERIOD_LIMIT, {24'h0, lim});
            wr(`OFS_UNIT1_CTRL, {26'h0, duty[1:0], 4'hC});
            wr(`OFS_DUTY1_UPPER, {24'h0, duty[9:2]});
            wr(`OFS_IRQ_STATUS, 32'h3);
            wr(`OFS_TIMER_CTRL, {25'h0, 4'($random(seed)), 1'b1, 2'(k)});
            if (k != 3) wait_period();
            wr(`OFS_PIN_DIR, 32'h6);
            @(posedge pclk);
            chk("pin driven", 32'h1, {31'h0, p1_oe});
            measure();
            chk("unit2 idle", 32'h0, {30'h0, p2, p2a});
            chk("period", 32'((lim + 1) * 4 * div_of(k)), {16'h0, period_len});
            chk("width", 32'(duty * div_of(k)), {16'h0, high_len});
        end
        $display("test pulse shapes done");
        // duty is buffered until the period ends
        wait_period();
        wr(`OFS_DUTY1_UPPER, 32'h00);
        wr(`OFS_UNIT1_CTRL, 32'h0C);
        wr(`OFS_DUTY1_SHADOW, 32'h55);
        rd_reg(`OFS_DUTY1_SHADOW, rd);
        chk("shadow held", {24'h0, duty[9:2]}, rd);
        wait_period();
        rd_reg(`OFS_DUTY1_SHADOW, rd);
        chk("shadow loaded", 32'h0, rd);
        r0 = rises;
        wait_period();
        chk("zero duty no pulse", {16'h0, r0}, {16'h0, rises});
        chk("zero duty pin low", 32'h0, {31'h0, p1});
        $display("test duty buffer done");
        // sleep freezes the timer
        wr(`OFS_SLEEP_CTRL, 32'h1);
        rd_reg(`OFS_TIMER_COUNT, rd);
        repeat (300) @(posedge pclk);
        rd_reg(`OFS_TIMER_COUNT, rd2);
        chk("sleep count", rd, rd2);
        wr(`OFS_SLEEP_CTRL, 32'h0);
        wait_period();
        // run bit off stops counting
        wr(`OFS_TIMER_CTRL, 32'h2);
        rd_reg(`OFS_TIMER_COUNT, rd);
        repeat (200) @(posedge pclk);
        rd_reg(`OFS_TIMER_COUNT, rd2);
        chk("stopped count", rd, rd2);
        $display("test sleep and stop done");
        // interrupt raised, masked, cleared
        wr(`OFS_IRQ_MASK, 32'h2);
        @(posedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`OFS_IRQ_MASK, 32'h0);
        @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`OFS_IRQ_MASK, 32'h2);
        wr(`OFS_IRQ_STATUS, 32'h3);
        rd_reg(`OFS_IRQ_STATUS, rd);
        chk("status cleared", 32'h0, rd);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        // reset in mid-run
        wr(`OFS_TIMER_CTRL, 32'h4);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd_reg(`OFS_PIN_DIR, rd);
        chk("dir after reset", 32'h7, rd);
        rd_reg(`OFS_TIMER_CTRL, rd);
        chk("timer ctrl after reset", 32'h0, rd);
        $display("test second reset done");
        summarize();
    end
endmodule
